// file: verilog/cfs_fanout_gate.sv
/*
 * clock fanout with source select and glitch-free common enable.
 * assumes all pins are sampled levels synchronous to clk_sys, and that the
 * selected reference toggles well below half the clk_sys rate.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cfs_params.svh"

// Functional notes
// - select high routes single-ended, low routes differential
// - open select pin reads low
// - enable low turns all outputs on
// - enable high holds every pair low
// - gate changes only while the clock is low
// - enable captured on selected clock falling edge
// - five pairs with true and complement
// - open differential halves read true low, inverting high
// - open single-ended clock reads low
// - open enable pin reads low, outputs enabled

module cfs_fanout_gate
    import cfs_pkg::*;
#(
    parameter int NUM_OUTPUTS = `CFS_NUM_OUTPUTS
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire cfs_pins_t pin_level,
    input wire cfs_pins_t pin_open,
    output cfs_pair_t fanout_out_zero,
    output cfs_pair_t fanout_out_one,
    output cfs_pair_t fanout_out_two,
    output cfs_pair_t fanout_out_three,
    output cfs_pair_t fanout_out_four
);

    // ----------------------------------------------------------------
    // assertion clock and reset
    // ----------------------------------------------------------------
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // pin pulls
    // ----------------------------------------------------------------
    localparam logic [`CFS_NUM_PINS-1:0] PIN_DEFAULTS = `CFS_PIN_DEFAULTS;

    wire logic [`CFS_NUM_PINS-1:0] level_vec;
    wire logic [`CFS_NUM_PINS-1:0] open_vec;
    wire logic [`CFS_NUM_PINS-1:0] eff_vec;

    assign level_vec = pin_level;
    assign open_vec = pin_open;

    genvar gp;
    generate
        for (gp = 0; gp < `CFS_NUM_PINS; gp = gp + 1) begin : g_pull
            cfs_pull_default #(
                .DEFAULT_LEVEL(PIN_DEFAULTS[gp])
            ) u_pull (
                .level(level_vec[gp]),
                .open(open_vec[gp]),
                .level_eff(eff_vec[gp])
            );
        end
    endgenerate

    wire logic diff_p_eff;
    wire logic diff_n_eff;
    wire logic single_eff;
    wire logic sel_eff;
    wire logic enable_n_eff;

    assign diff_p_eff = eff_vec[`CFS_POS_DIFF_P];
    assign diff_n_eff = eff_vec[`CFS_POS_DIFF_N];
    assign single_eff = eff_vec[`CFS_POS_SINGLE];
    assign sel_eff = eff_vec[`CFS_POS_SEL];
    assign enable_n_eff = eff_vec[`CFS_POS_ENABLE_N];

    // ----------------------------------------------------------------
    // source select
    // ----------------------------------------------------------------
    // a pair reads high only when the halves disagree the right way
    wire logic diff_level;
    wire logic sel_clk;

    assign diff_level = diff_p_eff & ~diff_n_eff;
    assign sel_clk = sel_eff ? single_eff : diff_level;

    // ----------------------------------------------------------------
    // falling edge of the selected clock
    // ----------------------------------------------------------------
    logic sel_clk_q;
    wire logic sel_fall;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_clk_q <= `CFS_RST_SAMPLE;
        end else begin
            sel_clk_q <= sel_clk;
        end
    end

    assign sel_fall = sel_clk_q & ~sel_clk;

    // ----------------------------------------------------------------
    // enable gate, moves only on a falling edge so the clock is low
    // ----------------------------------------------------------------
    cfs_gate_t gate_state;
    cfs_gate_t next_gate_state;

    always_comb begin
        next_gate_state = gate_state;
        case (gate_state)
            CFS_GATE_OFF: begin
                if (sel_fall && !enable_n_eff) begin
                    next_gate_state = CFS_GATE_ON;
                end
            end
            CFS_GATE_ON: begin
                if (sel_fall && enable_n_eff) begin
                    next_gate_state = CFS_GATE_OFF;
                end
            end
            default: begin
                next_gate_state = CFS_GATE_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gate_state <= CFS_GATE_OFF;
        end else begin
            gate_state <= next_gate_state;
        end
    end

    wire logic gate_on;
    wire logic gated_clk;

    assign gate_on = (gate_state == CFS_GATE_ON);
    // gate masks the mux output, it never retimes the clock edges
    assign gated_clk = sel_clk & gate_on;

    // ----------------------------------------------------------------
    // output pairs
    // ----------------------------------------------------------------
    cfs_pair_t pair_q [NUM_OUTPUTS];

    genvar go;
    generate
        for (go = 0; go < NUM_OUTPUTS; go = go + 1) begin : g_out
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    pair_q[go].true_out <= `CFS_RST_TRUE;
                    pair_q[go].comp_out <= `CFS_RST_COMP;
                end else begin
                    pair_q[go].true_out <= gated_clk;
                    pair_q[go].comp_out <= ~gated_clk;
                end
            end

            property p_pair_comp;
                @(posedge clk_sys) disable iff (rst)
                pair_q[go].comp_out == ~pair_q[go].true_out;
            endproperty
            a_pair_comp: assert property (p_pair_comp)
                else $error("output pair halves not complementary");
        end
    endgenerate

    assign fanout_out_zero = pair_q[0];
    assign fanout_out_one = pair_q[1];
    assign fanout_out_two = pair_q[2];
    assign fanout_out_three = pair_q[3];
    assign fanout_out_four = pair_q[4];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_fall_enable;
        sel_clk ##1 (!sel_clk && !enable_n_eff);
    endsequence

    sequence s_fall_disable;
        sel_clk ##1 (!sel_clk && enable_n_eff);
    endsequence

    property p_route_single;
        (gate_on && sel_eff) |=> (pair_q[0].true_out == $past(single_eff));
    endproperty
    a_route_single: assert property (p_route_single)
        else $error("single-ended clock not routed with select high");

    property p_route_diff;
        (gate_on && !sel_eff) |=> (pair_q[4].true_out == $past(diff_level));
    endproperty
    a_route_diff: assert property (p_route_diff)
        else $error("differential clock not routed with select low");

    property p_sel_open;
        pin_open.sel |-> (sel_clk == diff_level);
    endproperty
    a_sel_open: assert property (p_sel_open)
        else $error("open select pin did not choose the differential pair");

    property p_enable_on;
        s_fall_enable |=> gate_on;
    endproperty
    a_enable_on: assert property (p_enable_on)
        else $error("outputs not enabled after falling edge with enable low");

    property p_disable_low;
        s_fall_disable |=> (!gate_on ##1 (!pair_q[0].true_out && !pair_q[2].true_out));
    endproperty
    a_disable_low: assert property (p_disable_low)
        else $error("outputs not held low after disable");

    property p_change_low;
        $changed(gate_state) |-> ($past(sel_clk) == 1'b0) && !pair_q[1].true_out;
    endproperty
    a_change_low: assert property (p_change_low)
        else $error("gate changed while clock was high");

    property p_hold_no_fall;
        !sel_fall |=> $stable(gate_state);
    endproperty
    a_hold_no_fall: assert property (p_hold_no_fall)
        else $error("gate moved without a falling edge");

    property p_diff_open;
        (pin_open.diff_p && pin_open.diff_n) |-> (!diff_p_eff && diff_n_eff && !diff_level);
    endproperty
    a_diff_open: assert property (p_diff_open)
        else $error("open differential input did not fall to its defaults");

    property p_single_open;
        pin_open.single |-> !single_eff;
    endproperty
    a_single_open: assert property (p_single_open)
        else $error("open single-ended clock did not read low");

    property p_enable_open;
        (pin_open.enable_n && sel_fall) |=> gate_on;
    endproperty
    a_enable_open: assert property (p_enable_open)
        else $error("open enable pin did not enable the outputs");

    property p_follow_mux;
        (gate_on && $past(gate_on)) |=> (pair_q[3].true_out == $past(sel_clk));
    endproperty
    a_follow_mux: assert property (p_follow_mux)
        else $error("enabled output does not follow the selected clock");

    property p_off_low;
        !gate_on |=> !(pair_q[0].true_out || pair_q[1].true_out || pair_q[2].true_out
            || pair_q[3].true_out || pair_q[4].true_out);
    endproperty
    a_off_low: assert property (p_off_low)
        else $error("an output went high while the gate was off");

    property p_pairs_match;
        (pair_q[1] == pair_q[0]) && (pair_q[2] == pair_q[0]) && (pair_q[3] == pair_q[0]) && (pair_q[4] == pair_q[0]);
    endproperty
    a_pairs_match: assert property (p_pairs_match)
        else $error("output pairs differ from each other");

    property p_rise_low;
        $rose(gate_on) |-> !pair_q[0].true_out && !$past(sel_clk);
    endproperty
    a_rise_low: assert property (p_rise_low)
        else $error("outputs enabled while not low");

    property p_fell_low;
        $fell(gate_on) |-> !pair_q[4].true_out && !$past(sel_clk);
    endproperty
    a_fell_low: assert property (p_fell_low)
        else $error("outputs disabled while not low");

    property p_no_early_enable;
        (!gate_on && !sel_fall) |=> !gate_on;
    endproperty
    a_no_early_enable: assert property (p_no_early_enable)
        else $error("gate opened without a falling edge");

    property p_no_early_disable;
        (gate_on && !sel_fall) |=> gate_on;
    endproperty
    a_no_early_disable: assert property (p_no_early_disable)
        else $error("gate closed without a falling edge");

    property p_single_open_route;
        (pin_open.single && sel_eff) |-> !sel_clk;
    endproperty
    a_single_open_route: assert property (p_single_open_route)
        else $error("open single-ended clock selected but not low");

    property p_open_pair_low;
        (pin_open.diff_p && pin_open.diff_n && !sel_eff) |-> !sel_clk;
    endproperty
    a_open_pair_low: assert property (p_open_pair_low)
        else $error("open differential pair selected but not low");

endmodule

`default_nettype wire

// file: verilog/cfs_params.svh
/*
 * constants of the clock fanout select and gate block: pin defaults,
 * output count and reset values.
 * assumes it is included by bare name from the package and the modules.
 */
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH

// ----------------------------------------------------------------
// pin count and field positions of the packed pin vector
// ----------------------------------------------------------------
`define CFS_NUM_PINS 5
`define CFS_POS_DIFF_P 4
`define CFS_POS_DIFF_N 3
`define CFS_POS_SINGLE 2
`define CFS_POS_SEL 1
`define CFS_POS_ENABLE_N 0

// ----------------------------------------------------------------
// levels that an unconnected pin falls back to
// ----------------------------------------------------------------
`define CFS_OPEN_DIFF_P 1'b0
`define CFS_OPEN_DIFF_N 1'b1
`define CFS_OPEN_SINGLE 1'b0
`define CFS_OPEN_SEL 1'b0
`define CFS_OPEN_ENABLE_N 1'b0
`define CFS_PIN_DEFAULTS 5'h08

// ----------------------------------------------------------------
// output count and reset values
// ----------------------------------------------------------------
`define CFS_NUM_OUTPUTS 5
`define CFS_RST_SAMPLE 1'b0
`define CFS_RST_TRUE 1'b0
`define CFS_RST_COMP 1'b1

`endif

// file: verilog/cfs_pkg.sv
/*
 * types of the clock fanout select and gate block.
 * assumes cfs_params.svh is on the include path.
 */
`default_nettype none
`include "cfs_params.svh"

package cfs_pkg;

    // ----------------------------------------------------------------
    // pin group, one bit per input pin, order matches the params header
    // ----------------------------------------------------------------
    typedef struct packed {
        logic diff_p;
        logic diff_n;
        logic single;
        logic sel;
        logic enable_n;
    } cfs_pins_t;

    // ----------------------------------------------------------------
    // one differential output pair
    // ----------------------------------------------------------------
    typedef struct packed {
        logic true_out;
        logic comp_out;
    } cfs_pair_t;

    // ----------------------------------------------------------------
    // output gate state, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CFS_GATE_OFF = 2'b01,
        CFS_GATE_ON = 2'b10
    } cfs_gate_t;

endpackage

`default_nettype wire

// file: verilog/cfs_pull_default.sv
/*
 * one input pin with an internal pull: an open pin reads as its default.
 * assumes the open flag tells that nothing drives the pin.
 */
`timescale 1ns/100ps
`default_nettype none

module cfs_pull_default
    import cfs_pkg::*;
#(
    parameter logic DEFAULT_LEVEL = 1'b0
) (
    input wire logic level,
    input wire logic open,
    output logic level_eff
);

    // ----------------------------------------------------------------
    // pull resolution
    // ----------------------------------------------------------------
    assign level_eff = open ? DEFAULT_LEVEL : level;

endmodule

`default_nettype wire

// file: bench/cfs_ref_source.sv
/*
 * reference clock source model: differential pair and single-ended clock.
 * assumes clk_sys at 200 MHz; levels change just after its falling edge.
 */
`timescale 1ns/100ps
`default_nettype none

module cfs_ref_source (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic [3:0] half_diff,
    input wire logic [3:0] half_single,
    output logic diff_p,
    output logic diff_n,
    output logic single
);
    // ----------------------------------------------------------------
    // toggle counters, clocks stand still low while stopped
    // ----------------------------------------------------------------
    int cnt_d = 0;
    int cnt_s = 0;

    initial begin
        diff_p = 1'b0;
        diff_n = 1'b1;
        single = 1'b0;
    end

    always @(negedge clk_sys) begin
        if (!run) begin
            diff_p <= 1'b0;
            diff_n <= 1'b1;
            single <= 1'b0;
            cnt_d <= 0;
            cnt_s <= 0;
        end else begin
            cnt_d <= (cnt_d + 1 >= half_diff) ? 0 : cnt_d + 1;
            cnt_s <= (cnt_s + 1 >= half_single) ? 0 : cnt_s + 1;
            if (cnt_d + 1 >= half_diff) begin
                diff_p <= ~diff_p;
                diff_n <= diff_p;
            end
            if (cnt_s + 1 >= half_single) begin
                single <= ~single;
            end
        end
    end
endmodule

`default_nettype wire

// file: bench/tb_clock_fanout_select_gate.sv
/*
 * testbench of the clock fanout select and gate block, with a reference model.
 * assumes cfs_pkg, cfs_fanout_gate and cfs_ref_source are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cfs_params.svh"

`define TB_CHECK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module tb_clock_fanout_select_gate;
    import cfs_pkg::*;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    cfs_pins_t pin_level;
    cfs_pins_t pin_open = 5'h00;
    cfs_pair_t outs [5];
    logic run = 1'b1;
    logic [3:0] half_diff = 4'h2;
    logic [3:0] half_single = 4'h3;
    logic ref_p, ref_n, ref_s;
    logic sel = 1'b0;
    logic en_n = 1'b0;
    logic [4:0] noise = 5'h00;
    int fail_count = 0;
    int check_count = 0;
    int seed = 32'h041b;
    int m_true = 0;
    int m_gate = 0;
    int m_prev = 0;

    always #2.5 clk_sys = ~clk_sys;

    assign pin_level = {ref_p, ref_n, ref_s, sel, en_n} ^ (noise & pin_open);

    cfs_ref_source u_src (.clk_sys(clk_sys), .run(run), .half_diff(half_diff), .half_single(half_single),
        .diff_p(ref_p), .diff_n(ref_n), .single(ref_s));

    cfs_fanout_gate u_dut (.clk_sys(clk_sys), .rst(rst), .pin_level(pin_level), .pin_open(pin_open),
        .fanout_out_zero(outs[0]), .fanout_out_one(outs[1]), .fanout_out_two(outs[2]),
        .fanout_out_three(outs[3]), .fanout_out_four(outs[4]));

    // ----------------------------------------------------------------
    // reference model: pulls, select, falling edge gate, one cycle latency
    // ----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        logic [4:0] eff;
        int ck;
        if (rst) begin
            m_true <= 0;
            m_gate <= 0;
            m_prev <= 0;
        end else begin
            eff = (pin_level & ~pin_open) | (`CFS_PIN_DEFAULTS & pin_open);
            ck = eff[`CFS_POS_SEL] ? eff[`CFS_POS_SINGLE] : (eff[`CFS_POS_DIFF_P] & ~eff[`CFS_POS_DIFF_N]);
            m_true <= ck & m_gate;
            if (m_prev == 1 && ck == 0) begin
                m_gate <= eff[`CFS_POS_ENABLE_N] ? 0 : 1;
            end
            m_prev <= ck;
        end
    end

    // ----------------------------------------------------------------
    // compare every pair once per cycle where outputs are settled
    // ----------------------------------------------------------------
    always @(negedge clk_sys) begin
        for (int i = 0; i < 5; i++) begin
            `TB_CHECK("true_out", 1'(m_true), outs[i].true_out)
            `TB_CHECK("comp_out", 1'(~m_true), outs[i].comp_out)
        end
    end

    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic run_phase(input int cycles, input int flip_mask);
        repeat (cycles) begin
            @(negedge clk_sys);
            noise = 5'($random(seed));
            if (($random(seed) & flip_mask) == 0) begin
                en_n = ~en_n;
            end
        end
    endtask

    // ----------------------------------------------------------------
    // phases: source select, stopped clock, open pins, mid-run reset
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        run_phase(40, 32'hffff);
        for (int ph = 0; ph < 14; ph++) begin
            @(negedge clk_sys);
            sel = ph[0];
            run <= (ph % 6) != 5;
            half_diff <= 4'(1 + ph % 3);
            half_single <= 4'(2 + ph % 4);
            pin_open = (ph >= 8) ? 5'($random(seed)) : 5'h00;
            run_phase(150, (ph < 4) ? 7 : 15);
            if (ph == 7) begin
                rst = 1'b1;
                repeat (2) @(negedge clk_sys);
                rst = 1'b0;
            end
        end
        pin_open = 5'h1f;
        run_phase(60, 3);
        give_verdict();
    end

    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule

`default_nettype wire
